/* File: hw/afc_flow_ctl.sv */
/*
 * Automatic receive flow-control trigger with its AXI4-Lite register port.
 * Assumes the fill level, duplex, speed, transmit-enable and receive events
 * all come from MAC logic on the same clock, and that the MAC sends a pause
 * frame for each pause_req pulse.
 */
// Operation
// - Thresholds count 64-byte units; trigger at high
// - After pause, send zero pause below low
// - No pause or jam with transmitter off
// - Jam lasts the selected hold-time code
// - Hold-time code unused in full duplex
// - 100 Mb/s codes: 5,10,15,25, then 50-600 us
// - 10 Mb/s adds 2.2 us to each code
// - Multicast trigger jams multicast frames above threshold
// - Broadcast trigger jams broadcast frames above threshold
// - Address trigger jams own-address frames above threshold
// - Per-type triggers ignored in full duplex
// - Every-frame trigger; alone enables full-duplex pause
// - Half duplex every-frame jams on valid preamble
// - Full duplex requests pause at threshold immediately
// - Every-frame trigger overrides per-type triggers
`timescale 1ns/10ps
module afc_flow_ctl #(
	parameter int unsigned FILL_W = 14
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// Register port
	input  wire afc_pkg::afc_axil_req_t axil_req,
	output afc_pkg::afc_axil_rsp_t      axil_rsp,
	// MAC status
	input  wire logic [FILL_W-1:0]     rx_fill_bytes,
	input  wire logic                  full_duplex,
	input  wire logic                  speed_100,
	input  wire logic                  tx_enabled,
	input  wire afc_pkg::afc_rx_evt_t   rx_evt,
	// Flow-control actions
	output logic                       pause_req,
	output logic                       pause_zero,
	output logic                       back_pressure
);
	import afc_pkg::*;

	localparam int unsigned UNIT_W = FILL_W - FILL_UNIT_SHIFT;

	// Register port state
	logic                  aw_got_r;
	logic                  aw_got_nxt;
	logic [AXI_ADDR_W-1:0] awaddr_r;
	logic [AXI_ADDR_W-1:0] awaddr_nxt;
	logic                  w_got_r;
	logic                  w_got_nxt;
	logic [31:0]           wdata_r;
	logic [31:0]           wdata_nxt;
	logic [3:0]            wstrb_r;
	logic [3:0]            wstrb_nxt;
	logic                  awready_r;
	logic                  awready_nxt;
	logic                  wready_r;
	logic                  wready_nxt;
	logic                  bvalid_r;
	logic                  bvalid_nxt;
	logic [1:0]            bresp_r;
	logic [1:0]            bresp_nxt;
	logic                  arready_r;
	logic                  arready_nxt;
	logic                  rvalid_r;
	logic                  rvalid_nxt;
	logic [31:0]           rdata_r;
	logic [31:0]           rdata_nxt;
	logic [1:0]            rresp_r;
	logic [1:0]            rresp_nxt;
	afc_config_t           cfg_r;
	afc_config_t           cfg_nxt;
	logic [31:0]           cfg_word;

	// Flow-control state
	afc_fd_state_t         fd_state_r;
	afc_fd_state_t         fd_state_nxt;
	logic                  pause_req_r;
	logic                  pause_req_nxt;
	logic                  pause_zero_r;
	logic                  pause_zero_nxt;
	logic                  bp_r;
	logic                  bp_nxt;
	logic                  above_r;
	logic                  above_nxt;
	afc_stat_t             stat;

	// Combinational helpers
	logic [UNIT_W-1:0]     fill_units;
	logic                  above_high;
	logic                  below_low;
	logic                  type_hit;
	logic                  jam_trigger;
	logic                  jam_busy;
	logic [JAM_TICK_W-1:0] jam_ticks;

	function automatic logic addr_is(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] off);
		return a[AXI_ADDR_W-1:2] == off[AXI_ADDR_W-1:2];
	endfunction : addr_is

	assign stat = '{rsvd: '0, pause_outstanding: (fd_state_r == AFC_FD_PAUSED),
		jamming: bp_r, above_high: above_r};

	// AXI4-Lite slave: address and data are latched independently
	always_comb begin
		aw_got_nxt = aw_got_r;
		awaddr_nxt = awaddr_r;
		w_got_nxt  = w_got_r;
		wdata_nxt  = wdata_r;
		wstrb_nxt  = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		cfg_nxt    = cfg_r;
		cfg_word   = cfg_r;
		if (awready_r && axil_req.awvalid) begin
			aw_got_nxt = 1'b1;
			awaddr_nxt = axil_req.awaddr;
		end
		if (wready_r && axil_req.wvalid) begin
			w_got_nxt = 1'b1;
			wdata_nxt = axil_req.wdata;
			wstrb_nxt = axil_req.wstrb;
		end
		if (bvalid_r && axil_req.bready) begin
			bvalid_nxt = 1'b0;
		end
		// The write completes only once the previous response is gone
		if (aw_got_r && w_got_r && !bvalid_r) begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = AXI_RESP_OKAY;
			if (addr_is(awaddr_r, CFG_OFFSET)) begin
				for (int i = 0; i < 4; i++) begin
					if (wstrb_r[i]) begin
						cfg_word[8*i +: 8] = wdata_r[8*i +: 8];
					end
				end
				cfg_nxt = afc_config_t'(cfg_word & CFG_WR_MASK);
			end else if (!addr_is(awaddr_r, STAT_OFFSET)) begin
				bresp_nxt = AXI_RESP_SLVERR;
			end
		end
		if (rvalid_r && axil_req.rready) begin
			rvalid_nxt = 1'b0;
		end
		if (arready_r && axil_req.arvalid) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = AXI_RESP_OKAY;
			if (addr_is(axil_req.araddr, CFG_OFFSET)) begin
				rdata_nxt = cfg_r;
			end else if (addr_is(axil_req.araddr, STAT_OFFSET)) begin
				rdata_nxt = stat;
			end else begin
				rdata_nxt = '0;
				rresp_nxt = AXI_RESP_SLVERR;
			end
		end
		awready_nxt = !aw_got_nxt;
		wready_nxt  = !w_got_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_got_r  <= 1'b0;
			awaddr_r  <= '0;
			w_got_r   <= 1'b0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= AXI_RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= '0;
			rresp_r   <= AXI_RESP_OKAY;
			cfg_r     <= afc_config_t'(CFG_RESET);
		end else begin
			aw_got_r  <= aw_got_nxt;
			awaddr_r  <= awaddr_nxt;
			w_got_r   <= w_got_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
			cfg_r     <= cfg_nxt;
		end
	end

	assign axil_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
		bresp: bresp_r, arready: arready_r, rvalid: rvalid_r, rdata: rdata_r,
		rresp: rresp_r};

	// Threshold compare in 64-byte units
	always_comb begin
		fill_units = rx_fill_bytes[FILL_W-1:FILL_UNIT_SHIFT];
		above_high = fill_units >= UNIT_W'(cfg_r.high_fill_threshold);
		// Low must stay under high or the zero pause follows at once
		below_low  = fill_units < UNIT_W'(cfg_r.low_fill_threshold);
	end

	// Half-duplex jam trigger
	always_comb begin
		type_hit = (cfg_r.trigger_on_multicast && rx_evt.multicast)
			|| (cfg_r.trigger_on_broadcast && rx_evt.broadcast)
			|| (cfg_r.trigger_on_own_address && rx_evt.own_address);
		jam_trigger = 1'b0;
		if (!full_duplex && tx_enabled && above_high) begin
			if (cfg_r.trigger_on_every_frame) begin
				jam_trigger = rx_evt.preamble;
			end else begin
				jam_trigger = rx_evt.addr_done && type_hit;
			end
		end
		jam_ticks = afc_jam_ticks(cfg_r.jam_hold_time, speed_100);
	end

	// Each triggering frame reloads the hold, so a burst keeps the jam on
	afc_hold_timer #(
		.TICK_CYC (JAM_TICK_CYC),
		.CNT_W    (JAM_TICK_W)
	) u_hold (
		.clk        (clk),
		.resetn     (resetn),
		.load       (jam_trigger),
		.load_ticks (jam_ticks),
		.busy       (jam_busy)
	);

	// Full-duplex pause sequencing and back-pressure output
	always_comb begin
		fd_state_nxt   = fd_state_r;
		pause_req_nxt  = 1'b0;
		pause_zero_nxt = pause_zero_r;
		unique case (fd_state_r)
			AFC_FD_WATCH: begin
				if (full_duplex && cfg_r.trigger_on_every_frame && tx_enabled && above_high) begin
					pause_req_nxt  = 1'b1;
					pause_zero_nxt = 1'b0;
					fd_state_nxt   = AFC_FD_PAUSED;
				end
			end
			AFC_FD_PAUSED: begin
				if (!full_duplex || !cfg_r.trigger_on_every_frame) begin
					fd_state_nxt = AFC_FD_WATCH;
				end else if (tx_enabled && below_low) begin
					pause_req_nxt  = 1'b1;
					pause_zero_nxt = 1'b1;
					fd_state_nxt   = AFC_FD_WATCH;
				end
			end
		endcase
		// Hold code has no effect in full duplex
		bp_nxt    = jam_busy && tx_enabled && !full_duplex;
		above_nxt = above_high;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fd_state_r   <= AFC_FD_WATCH;
			pause_req_r  <= 1'b0;
			pause_zero_r <= 1'b0;
			bp_r         <= 1'b0;
			above_r      <= 1'b0;
		end else begin
			fd_state_r   <= fd_state_nxt;
			pause_req_r  <= pause_req_nxt;
			pause_zero_r <= pause_zero_nxt;
			bp_r         <= bp_nxt;
			above_r      <= above_nxt;
		end
	end

	assign pause_req     = pause_req_r;
	assign pause_zero    = pause_zero_r;
	assign back_pressure = bp_r;

endmodule : afc_flow_ctl

/* File: hw/afc_pkg.sv */
/*
 * Shared constants, register layouts and carrier types for the automatic
 * flow-control trigger.
 * Assumes a 125 MHz MAC clock and an AXI4-Lite register port with 32-bit data.
 */
package afc_pkg;

	// Clock and back-pressure timebase
	localparam int unsigned CLK_PERIOD_NS    = 8;
	localparam int unsigned JAM_TICK_NS      = 200;
	localparam int unsigned JAM_TICK_CYC     = JAM_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned JAM_TICK_W       = 12;

	// Hold times in ns at 100 Mb/s; 10 Mb/s adds a fixed extra
	localparam int unsigned JAM_CODE0_NS     = 5000;
	localparam int unsigned JAM_CODE1_NS     = 10000;
	localparam int unsigned JAM_CODE2_NS     = 15000;
	localparam int unsigned JAM_CODE3_NS     = 25000;
	localparam int unsigned JAM_STEP_NS      = 50000;
	localparam int unsigned JAM_STEP_BASE    = 3;
	localparam int unsigned JAM_10M_EXTRA_NS = 2200;

	// Fill levels are compared in 64-byte units
	localparam int unsigned FILL_UNIT_SHIFT  = 6;

	// Register map (byte addresses)
	localparam int unsigned AXI_ADDR_W       = 8;
	localparam logic [7:0]  CFG_OFFSET       = 8'hac;
	localparam logic [7:0]  STAT_OFFSET      = 8'hb0;
	localparam logic [31:0] CFG_RESET        = 32'h0000_0000;
	localparam logic [31:0] CFG_WR_MASK      = 32'h00ff_ffff;
	localparam logic [1:0]  AXI_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  AXI_RESP_SLVERR  = 2'h2;

	// Configuration word, bit 31 first
	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] high_fill_threshold;
		logic [7:0] low_fill_threshold;
		logic [3:0] jam_hold_time;
		logic       trigger_on_multicast;
		logic       trigger_on_broadcast;
		logic       trigger_on_own_address;
		logic       trigger_on_every_frame;
	} afc_config_t;

	typedef struct packed {
		logic [28:0] rsvd;
		logic        pause_outstanding;
		logic        jamming;
		logic        above_high;
	} afc_stat_t;

	// Receive events from the MAC; preamble and addr_done are one-cycle pulses
	typedef struct packed {
		logic preamble;
		logic addr_done;
		logic multicast;
		logic broadcast;
		logic own_address;
	} afc_rx_evt_t;

	typedef struct packed {
		logic                  awvalid;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic                  wvalid;
		logic [31:0]           wdata;
		logic [3:0]            wstrb;
		logic                  bready;
		logic                  arvalid;
		logic [AXI_ADDR_W-1:0] araddr;
		logic                  rready;
	} afc_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} afc_axil_rsp_t;

	typedef enum logic {
		AFC_FD_WATCH,
		AFC_FD_PAUSED
	} afc_fd_state_t;

	// Hold time in timebase ticks for a duration code and line rate
	function automatic logic [JAM_TICK_W-1:0] afc_jam_ticks(input logic [3:0] code, input logic is_100);
		int unsigned ns;
		case (code)
			4'h0:    ns = JAM_CODE0_NS;
			4'h1:    ns = JAM_CODE1_NS;
			4'h2:    ns = JAM_CODE2_NS;
			4'h3:    ns = JAM_CODE3_NS;
			default: ns = (int'(code) - JAM_STEP_BASE) * JAM_STEP_NS;
		endcase
		if (!is_100) begin
			ns = ns + JAM_10M_EXTRA_NS;
		end
		return JAM_TICK_W'(ns / JAM_TICK_NS);
	endfunction : afc_jam_ticks

endpackage : afc_pkg

/* File: hw/afc_hold_timer.sv */
/*
 * Back-pressure hold timer: a timebase prescaler and a tick down-counter.
 * Assumes load is a one-cycle pulse on the MAC clock and load_ticks is non-zero.
 */
`timescale 1ns/10ps
module afc_hold_timer #(
	parameter int unsigned TICK_CYC = afc_pkg::JAM_TICK_CYC,
	parameter int unsigned CNT_W    = afc_pkg::JAM_TICK_W
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Control
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_ticks,
	// Status
	output logic                  busy
);
	import afc_pkg::*;

	localparam int unsigned PRE_W = $clog2(TICK_CYC + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);

	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] pre_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             busy_r;
	logic             busy_nxt;

	// Prescaler runs freely but restarts on load so the hold is exact
	always_comb begin
		pre_nxt = (pre_r == PRE_LAST) ? '0 : pre_r + PRE_W'(1);
		cnt_nxt = cnt_r;
		if (load) begin
			pre_nxt = '0;
			cnt_nxt = load_ticks;
		end else if (pre_r == PRE_LAST && cnt_r != '0) begin
			cnt_nxt = cnt_r - CNT_W'(1);
		end
		busy_nxt = (cnt_nxt != '0);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pre_r  <= '0;
			cnt_r  <= '0;
			busy_r <= 1'b0;
		end else begin
			pre_r  <= pre_nxt;
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign busy = busy_r;

endmodule : afc_hold_timer

/* File: testbench/afc_flow_ctl_assertions.sv */
/*
 * Concurrent checks on the flow-control trigger ports, bound into afc_flow_ctl.
 * Assumes the bench writes whole words with address and data taken together.
 */
`timescale 1ns/10ps
module afc_flow_ctl_checker #(
	parameter int unsigned FILL_W = 14
) (
	input wire logic                   clk,
	input wire logic                   resetn,
	input wire afc_pkg::afc_axil_req_t axil_req,
	input wire afc_pkg::afc_axil_rsp_t axil_rsp,
	input wire logic [FILL_W-1:0]      rx_fill_bytes,
	input wire logic                   full_duplex,
	input wire logic                   speed_100,
	input wire logic                   tx_enabled,
	input wire afc_pkg::afc_rx_evt_t   rx_evt,
	input wire logic                   pause_req,
	input wire logic                   pause_zero,
	input wire logic                   back_pressure
);
	import afc_pkg::*;
	afc_config_t       cfg_r;
	afc_config_t       cfg_nxt;
	logic [FILL_W-1:0] units;
	logic              hi_ok;
	logic              trig;
	logic              rd_take;

	// Shadow copy one edge early; harmless since the bench never triggers mid-write
	always_comb begin
		cfg_nxt = cfg_r;
		if (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready &&
			axil_req.awaddr == CFG_OFFSET) begin
			cfg_nxt = afc_config_t'(axil_req.wdata & CFG_WR_MASK);
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r <= afc_config_t'(CFG_RESET);
		end else begin
			cfg_r <= cfg_nxt;
		end
	end
	assign units   = rx_fill_bytes >> FILL_UNIT_SHIFT;
	assign hi_ok   = units >= FILL_W'(cfg_r.high_fill_threshold);
	assign trig    = tx_enabled && !full_duplex && hi_ok && (cfg_r.trigger_on_every_frame ? rx_evt.preamble :
		rx_evt.addr_done && ((cfg_r.trigger_on_multicast && rx_evt.multicast) ||
		(cfg_r.trigger_on_broadcast && rx_evt.broadcast) || (cfg_r.trigger_on_own_address && rx_evt.own_address)));
	assign rd_take = axil_req.arvalid && axil_rsp.arready;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence jam_on_s;
		##2 back_pressure;
	endsequence
	sequence pause_one_s;
		pause_req ##1 !pause_req;
	endsequence

	jam_start_a: assert property (trig |-> jam_on_s)
		else $error("back pressure did not start two cycles after a trigger");
	jam_cause_a: assert property ($rose(back_pressure) |-> $past(trig, 2))
		else $error("back pressure started without a trigger");
	jam_txoff_a: assert property (!tx_enabled [*2] |=> !back_pressure)
		else $error("back pressure with transmitter off");
	jam_fdx_a: assert property (full_duplex [*2] |=> !back_pressure)
		else $error("back pressure in full duplex");
	pause_txon_a: assert property (pause_req |-> $past(tx_enabled && full_duplex))
		else $error("pause requested off full duplex or with transmitter off");
	pause_high_a: assert property (pause_req && !pause_zero |-> $past(hi_ok && cfg_r.trigger_on_every_frame))
		else $error("pause requested below high threshold");
	pause_low_a: assert property (pause_req && pause_zero |-> $past(units < FILL_W'(cfg_r.low_fill_threshold)))
		else $error("zero pause requested at or above low threshold");
	pause_pulse_a: assert property (pause_req |-> pause_one_s)
		else $error("pause request longer than one cycle");
	zero_stands_a: assert property ($changed(pause_zero) |-> pause_req)
		else $error("pause kind changed without a request");
	rd_cfg_a: assert property (rd_take && axil_req.araddr == CFG_OFFSET |=> axil_rsp.rvalid && axil_rsp.rdata == 32'(cfg_r))
		else $error("configuration read back wrong");
	rd_unmapped_a: assert property (rd_take && axil_req.araddr != CFG_OFFSET && axil_req.araddr != STAT_OFFSET
		|=> axil_rsp.rresp == AXI_RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule : afc_flow_ctl_checker

bind afc_flow_ctl afc_flow_ctl_checker #(.FILL_W(FILL_W)) i_afc_flow_ctl_checker (
	.clk(clk), .resetn(resetn), .axil_req(axil_req), .axil_rsp(axil_rsp), .rx_fill_bytes(rx_fill_bytes),
	.full_duplex(full_duplex), .speed_100(speed_100), .tx_enabled(tx_enabled), .rx_evt(rx_evt),
	.pause_req(pause_req), .pause_zero(pause_zero), .back_pressure(back_pressure));

/* File: testbench/afc_link_partner.sv */
/*
 * Receive-event source standing for the remote station's frames.
 * Assumes it is called from the bench and that clk is the MAC clock.
 */
`timescale 1ns/10ps
module afc_link_partner (
	// Clock
	input wire logic             clk,
	// Receive events
	output afc_pkg::afc_rx_evt_t rx_evt
);
	import afc_pkg::*;
	initial rx_evt = '0;

	// Kind bits: multicast, broadcast, own address
	task automatic send_frame(input logic [2:0] kind);
		@(posedge clk);
		rx_evt.preamble <= 1'b1;
		@(posedge clk);
		rx_evt.preamble <= 1'b0;
		repeat (12) @(posedge clk);
		rx_evt.addr_done <= 1'b1;
		{rx_evt.multicast, rx_evt.broadcast, rx_evt.own_address} <= kind;
		@(posedge clk);
		rx_evt.addr_done <= 1'b0;
		// Qualifiers are meaningless outside the decode pulse, so they flip
		{rx_evt.multicast, rx_evt.broadcast, rx_evt.own_address} <= ~kind;
	endtask : send_frame
endmodule : afc_link_partner

/* File: testbench/tb_auto_flow_control_trigger.sv */
/*
 * Self-checking bench for afc_flow_ctl: register access and trigger scenarios.
 * Assumes the checker is bound in and the link partner model is compiled alongside.
 */
`timescale 1ns/10ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; \
	$display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module tb_auto_flow_control_trigger;
	import afc_pkg::*;
	logic           clk, resetn, fdx, spd, txen, pause_req, pause_zero, bp, last_zero;
	afc_axil_req_t  req;
	afc_axil_rsp_t  rsp;
	afc_rx_evt_t    evt;
	logic [13:0]    fill;
	logic [31:0]    rd;
	logic [1:0]     resp;
	int             mismatches, compares, cycles, n_pause, bp_len;

	afc_flow_ctl i_afc_flow_ctl (.clk(clk), .resetn(resetn), .axil_req(req), .axil_rsp(rsp), .rx_fill_bytes(fill),
		.full_duplex(fdx), .speed_100(spd), .tx_enabled(txen), .rx_evt(evt), .pause_req(pause_req),
		.pause_zero(pause_zero), .back_pressure(bp));
	afc_link_partner i_afc_link_partner (.clk(clk), .rx_evt(evt));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Sample at the falling edge so flop updates have settled
	always @(negedge clk) begin
		cycles++;
		if (pause_req === 1'b1) begin
			n_pause++;
			last_zero = pause_zero;
		end
		if (bp === 1'b1) bp_len++;
		if (cycles == 60000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok, b_ok;
		@(posedge clk);
		req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1; req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
		b_ok = 1'b0;
		while (!b_ok) begin
			@(negedge clk);
			aw_ok = req.awvalid && rsp.awready;
			w_ok = req.wvalid && rsp.wready;
			b_ok = rsp.bvalid;
			r = rsp.bresp;
			@(posedge clk);
			if (aw_ok) req.awvalid <= 1'b0;
			if (w_ok) req.wvalid <= 1'b0;
		end
		req.bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_ok, r_ok;
		@(posedge clk);
		req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
		r_ok = 1'b0;
		while (!r_ok) begin
			@(negedge clk);
			ar_ok = req.arvalid && rsp.arready;
			r_ok = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge clk);
			if (ar_ok) req.arvalid <= 1'b0;
		end
		req.rready <= 1'b0;
	endtask : axi_read

	function automatic int jam_cyc(input int code, input bit s100);
		int ns;
		ns = (code > 3) ? (code - 3) * 50000 : (code == 3) ? 25000 : (code + 1) * 5000;
		return (s100 ? ns : ns + 2200) / 8;
	endfunction : jam_cyc

	// Low 1 and high 2 in 64-byte units; every jam must have ended before the next case
	task automatic jam_case(input logic [3:0] trig, input logic [3:0] code, input logic s100, input logic [2:0] kind,
		input int exp_len);
		axi_write(CFG_OFFSET, {8'h00, 8'h02, 8'h01, code, trig}, resp);
		spd <= s100;
		bp_len = 0;
		i_afc_link_partner.send_frame(kind);
		repeat (exp_len + 40) @(posedge clk);
		`CHK("jam length", exp_len, bp_len)
	endtask : jam_case

	initial begin
		resetn = 1'b0; req = '0; fill = 14'h0000; fdx = 1'b0; spd = 1'b1; txen = 1'b1; last_zero = 1'bx;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		axi_read(CFG_OFFSET, rd, resp);
		`CHK("cfg reset", CFG_RESET, rd)
		axi_write(CFG_OFFSET, 32'hffff_ffff, resp);
		`CHK("cfg bresp", AXI_RESP_OKAY, resp)
		axi_read(CFG_OFFSET, rd, resp);
		`CHK("cfg readback", CFG_WR_MASK, rd)
		axi_write(8'h40, 32'h0000_0001, resp);
		`CHK("unmapped bresp", AXI_RESP_SLVERR, resp)
		axi_read(8'h40, rd, resp);
		`CHK("unmapped rresp", AXI_RESP_SLVERR, resp)
		fill <= 14'h0080;
		for (int c = 0; c < 5; c++) jam_case(4'h1, 4'(c), 1'b1, 3'b000, jam_cyc(c, 1'b1));
		jam_case(4'h1, 4'h0, 1'b0, 3'b000, jam_cyc(0, 1'b0));
		jam_case(4'h1, 4'h4, 1'b0, 3'b000, jam_cyc(4, 1'b0));
		fill <= 14'h007f;
		jam_case(4'h1, 4'h0, 1'b1, 3'b000, 0);
		fill <= 14'h0080;
		for (int i = 1; i < 4; i++) begin
			jam_case(4'(1 << i), 4'h0, 1'b1, 3'(1 << (i - 1)), 625);
			jam_case(4'(1 << i), 4'h0, 1'b1, ~3'(1 << (i - 1)), 0);
		end
		jam_case(4'hf, 4'h0, 1'b1, 3'b000, 625);
		txen <= 1'b0;
		jam_case(4'h1, 4'h0, 1'b1, 3'b000, 0);
		axi_write(CFG_OFFSET, 32'h0002_01fe, resp);
		fdx <= 1'b1;
		txen <= 1'b1;
		jam_case(4'he, 4'h0, 1'b1, 3'b111, 0);
		`CHK("pause count", 0, n_pause)
		txen <= 1'b0;
		axi_write(CFG_OFFSET, 32'h0002_0101, resp);
		repeat (20) @(posedge clk);
		`CHK("pause count", 0, n_pause)
		txen <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("pause count", 1, n_pause)
		`CHK("pause zero", 1'b0, last_zero)
		// Status: bit0 above high, bit1 jamming, bit2 zero pause still owed
		axi_read(STAT_OFFSET, rd, resp);
		`CHK("status paused", 32'h0000_0005, rd)
		fill <= 14'h0040;
		repeat (20) @(posedge clk);
		`CHK("pause count", 1, n_pause)
		fill <= 14'h003f;
		repeat (5) @(posedge clk);
		`CHK("pause count", 2, n_pause)
		`CHK("pause zero", 1'b1, last_zero)
		axi_write(STAT_OFFSET, 32'hffff_ffff, resp);
		`CHK("status bresp", AXI_RESP_OKAY, resp)
		axi_read(STAT_OFFSET, rd, resp);
		`CHK("status resumed", 32'h0000_0000, rd)
		tally_and_finish();
	end
endmodule : tb_auto_flow_control_trigger
